//--- pdrl_ctrl.sv
/*
  Power-down, power-up initialisation, slew, security lock and JTAG
  programming-port control for a programmable logic array.
  Assumes the core logic delivers next register values on core_d in the
  clk domain, and that pins, supply detect and JTAG pins are asynchronous.
*/
`timescale 1ns/1ps
// Operation
// R1 - Enabled power-down is entered while either assigned power-down pin is high.
// R2 - Power-down exists only if configured; otherwise those pins are logic.
// R3 - In power-down, internal registers and enabled outputs hold their values.
// R4 - Pin activity is ignored until the active power-down pin falls.
// R5 - A power-down pin is no logic input/output; its macrocell stays usable.
// R6 - Every output has its own slew choice, slow unless marked fast.
// R7 - After supply passes the threshold, registers initialise; outputs follow polarity.
// R8 - Outside logic meets setup times before the first clock rising edge.
// R9 - Outside logic keeps the clock still during reset_settle_time.
// R10 - A set security lock refuses readback of the configuration pattern.
// R11 - User signature and identification stay readable under the lock.
// R12 - In-system programming runs over the four-pin JTAG port.
// R13 - With the JTAG port disabled, its four pins become general I/O.
// R14 - Interrupted programming locks the device and floats all pin drivers; the code keeps the TDO driver on while the JTAG port is enabled.
// R15 - The test-port controller is reset automatically at power-up.
// R16 - Leaving power-down resumes from held state without reinitialising.
// R17 - Power-down, roles, slew, lock and JTAG enable are static configuration.
module pdrl_ctrl #(
  parameter int NPIN = pdrl_pkg::NPIN,
  parameter logic [31:0] ID_VALUE = 32'h0a5a_0001 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic supply_ok,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] core_d,
  input wire logic [NPIN-1:0] out_oe_req,
  output logic [NPIN-1:0] core_q,
  output logic [NPIN-1:0] pin_data,
  output pdrl_pkg::pdrl_pins_t pins,
  input wire logic [pdrl_pkg::NJTAG-1:0] jtag_pin_in,
  output logic [pdrl_pkg::NJTAG-1:0] jtag_pin_out,
  output logic [pdrl_pkg::NJTAG-1:0] jtag_pin_oe,
  input wire logic [pdrl_pkg::NJTAG-1:0] user_jtag_out,
  input wire logic [pdrl_pkg::NJTAG-1:0] user_jtag_oe,
  output logic [pdrl_pkg::NJTAG-1:0] user_jtag_in,
  output logic [pdrl_pkg::NJTAG-1:0] tap_pins,
  input wire logic tap_tdo,
  output logic tap_rst,
  input wire logic prog_start,
  input wire logic prog_done,
  input wire logic prog_abort,
  output logic powered_down,
  output logic ready,
  input wire logic [pdrl_pkg::ADDR_W-1:0] addr,
  input wire logic [pdrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pdrl_pkg::DATA_W-1:0] rdata
);

  localparam logic [pdrl_pkg::SETTLE_W-1:0] SETTLE_LAST =
    pdrl_pkg::SETTLE_W'(pdrl_pkg::SETTLE_CYC - 1);
  localparam int TDO_IDX = 3;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [NPIN-1:0] pin_sync;
  logic [pdrl_pkg::NJTAG-1:0] jtag_sync;
  logic supply_sync;

  pdrl_sync #(.W(NPIN)) u_pin_sync (
    .clk(clk), .ce(ce), .sys_rst(sys_rst), .d(pin_in), .q(pin_sync)
  );
  pdrl_sync #(.W(pdrl_pkg::NJTAG)) u_jtag_sync (
    .clk(clk), .ce(ce), .sys_rst(sys_rst), .d(jtag_pin_in), .q(jtag_sync)
  );
  pdrl_sync #(.W(1)) u_supply_sync (
    .clk(clk), .ce(ce), .sys_rst(sys_rst), .d(supply_ok), .q(supply_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers and register port decode.

  pdrl_pkg::pdrl_cfg_t cfg;
  logic [NPIN-1:0] slew_fast;
  logic [NPIN-1:0] polarity;
  logic [pdrl_pkg::DATA_W-1:0] user_sig;
  logic isp_locked;
  logic prog_busy;

  wire sel_cfg = addr == pdrl_pkg::CFG_OFS;
  wire sel_slew = addr == pdrl_pkg::SLEW_OFS;
  wire sel_polar = addr == pdrl_pkg::POLAR_OFS;
  wire sel_status = addr == pdrl_pkg::STATUS_OFS;
  wire sel_sig = addr == pdrl_pkg::SIG_OFS;
  wire sel_id = addr == pdrl_pkg::ID_OFS;
  wire sel_verify = addr == pdrl_pkg::VERIFY_OFS;

  // Static configuration changes only while programming is in progress.
  // R17 static configuration
  wire cfg_wr = wr && prog_busy;
  // Once set, the lock can only be cleared by a full reset.
  wire [pdrl_pkg::CFG_W-1:0] next_cfg =
    wdata[pdrl_pkg::CFG_W-1:0] | {cfg.lock, {(pdrl_pkg::CFG_W-1){1'b0}}};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg <= pdrl_pkg::CFG_RESET;
      slew_fast <= pdrl_pkg::SLEW_RESET;
      polarity <= pdrl_pkg::POLAR_RESET;
      user_sig <= pdrl_pkg::SIG_RESET;
    end
    else if (ce && cfg_wr)
    begin
      if (sel_cfg)
        cfg <= next_cfg;
      if (sel_slew)
        slew_fast <= wdata[NPIN-1:0];
      if (sel_polar)
        polarity <= wdata[NPIN-1:0];
      if (sel_sig)
        user_sig <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up sequencing and power-down state machine.

  pdrl_pkg::pdrl_state_t state;
  pdrl_pkg::pdrl_state_t next_state;
  logic [pdrl_pkg::SETTLE_W-1:0] settle_cnt;

  // R1 power-down request
  wire pd_a_req = cfg.pd_en && cfg.role_a && pin_sync[pdrl_pkg::PD_A_PIN];
  wire pd_b_req = cfg.pd_en && cfg.role_b && pin_sync[pdrl_pkg::PD_B_PIN];
  wire pd_req = pd_a_req || pd_b_req;
  wire settle_done = settle_cnt == SETTLE_LAST;

  always_comb
  begin
    next_state = state;
    unique case (state)
      pdrl_pkg::ST_OFF:
        if (supply_sync)
          next_state = pdrl_pkg::ST_SETTLE;
      pdrl_pkg::ST_SETTLE:
        if (!supply_sync)
          next_state = pdrl_pkg::ST_OFF;
        else if (settle_done)
          next_state = pdrl_pkg::ST_RUN;
      pdrl_pkg::ST_RUN:
        if (!supply_sync)
          next_state = pdrl_pkg::ST_OFF;
        else if (pd_req)
          next_state = pdrl_pkg::ST_PDOWN;
      pdrl_pkg::ST_PDOWN:
        if (!supply_sync)
          next_state = pdrl_pkg::ST_OFF;
        // R4 resume on pin low
        else if (!pd_req)
          next_state = pdrl_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= pdrl_pkg::ST_OFF;
    else if (ce)
      state <= next_state;
  end

  // R9 settle interval counted with no core clocking
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && state != pdrl_pkg::ST_SETTLE))
      settle_cnt <= '0;
    else if (ce && !settle_done)
      settle_cnt <= settle_cnt + 1'b1;
  end

  wire running = state == pdrl_pkg::ST_RUN;
  wire initialising = state != pdrl_pkg::ST_RUN && state != pdrl_pkg::ST_PDOWN;

  ////////////////////////////////////////////////////////////////////////
  // Core register hold and pin gating.

  // R5 power-down pins are no logic pins
  wire [NPIN-1:0] pd_role_mask =
    {{(NPIN-2){1'b0}}, cfg.pd_en && cfg.role_b, cfg.pd_en && cfg.role_a};

  // Core registers clear during initialisation, update while running and
  // keep their value in power-down, so leaving it needs no reload.
  // R7 register initialisation
  // R3 hold during power-down
  // R16 resume from held state
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && initialising))
      core_q <= '0;
    else if (ce && running)
      core_q <= core_d;
  end

  // R4 pin transitions ignored in power-down
  // R2 pins stay logic when power-down is off
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && initialising))
      pin_data <= '0;
    else if (ce && running)
      pin_data <= pin_sync & ~pd_role_mask;
  end

  // Output level follows polarity over the held register value.
  // R6 per-output slew
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pins <= '0;
    else if (ce && !(state == pdrl_pkg::ST_PDOWN))
    begin
      pins.level <= core_q ^ polarity;
      pins.oe <= isp_locked ? '0 : (out_oe_req & ~pd_role_mask);
      pins.fast <= slew_fast;
    end
    // R14 interrupted programming floats outputs
    else if (ce && isp_locked)
      pins.oe <= '0;
  end

  assign powered_down = state == pdrl_pkg::ST_PDOWN;
  assign ready = running;

  ////////////////////////////////////////////////////////////////////////
  // JTAG programming port.

  // R15 test-port reset at power-up
  assign tap_rst = initialising;

  // R12 four-pin programming port
  assign tap_pins = cfg.jtag_en ? jtag_sync : '0;
  // R13 JTAG pins released as general I/O
  assign user_jtag_in = cfg.jtag_en ? '0 : jtag_sync;

  always_comb
  begin
    jtag_pin_out = user_jtag_out;
    jtag_pin_oe = user_jtag_oe;
    if (cfg.jtag_en)
    begin
      jtag_pin_out = '0;
      jtag_pin_oe = '0;
      jtag_pin_out[TDO_IDX] = tap_tdo;
      jtag_pin_oe[TDO_IDX] = 1'b1;
    end
    else if (isp_locked)
      jtag_pin_oe = '0;
  end

  // R14 lock on interrupted programming; a later completion releases it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prog_busy <= 1'b0;
      isp_locked <= 1'b0;
    end
    else if (ce)
    begin
      prog_busy <= prog_start || (prog_busy && !prog_done && !prog_abort);
      isp_locked <= (prog_busy && prog_abort) || (isp_locked && !prog_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port.

  wire [pdrl_pkg::DATA_W-1:0] status_word =
    {{(pdrl_pkg::DATA_W-4){1'b0}}, isp_locked, cfg.lock, powered_down, ready};
  // R10 readback refused under the lock
  wire [pdrl_pkg::DATA_W-1:0] verify_word = cfg.lock ? '0 :
    {{(pdrl_pkg::DATA_W-pdrl_pkg::CFG_W){1'b0}}, cfg};
  // R11 signature and identification always readable
  wire [pdrl_pkg::DATA_W-1:0] read_mux =
    sel_cfg ? {{(pdrl_pkg::DATA_W-pdrl_pkg::CFG_W){1'b0}}, cfg} :
    sel_slew ? {{(pdrl_pkg::DATA_W-NPIN){1'b0}}, slew_fast} :
    sel_polar ? {{(pdrl_pkg::DATA_W-NPIN){1'b0}}, polarity} :
    sel_status ? status_word :
    sel_sig ? user_sig :
    sel_id ? ID_VALUE :
    sel_verify ? verify_word : '0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata <= '0;
    else if (ce)
      rdata <= rd ? read_mux : '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_pd_enter;
    ce && running && pd_req && supply_sync;
  endsequence

  sequence s_pd_held;
    ce && powered_down;
  endsequence

  // R1
  a_pd_entry_on_pin: assert property (@(posedge clk) disable iff (sys_rst)
    s_pd_enter |=> powered_down)
    else $error("power-down not entered on pin request");

  // R2
  a_pd_needs_enable: assert property (@(posedge clk) disable iff (sys_rst)
    ce && running && !cfg.pd_en |=> !powered_down)
    else $error("power-down entered while disabled");

  // R3
  a_core_hold_pd: assert property (@(posedge clk) disable iff (sys_rst)
    s_pd_held ##1 (powered_down || !ce) |-> $stable(core_q) && $stable(pins))
    else $error("state changed during power-down");

  // R4
  a_pin_ignore_pd: assert property (@(posedge clk) disable iff (sys_rst)
    powered_down |=> $stable(pin_data))
    else $error("pin data moved during power-down");

  // R5
  a_pd_pin_masked: assert property (@(posedge clk) disable iff (sys_rst)
    ce && cfg.pd_en && cfg.role_a && running
    |=> !pin_data[pdrl_pkg::PD_A_PIN])
    else $error("power-down pin used as logic input");

  // R6
  a_slew_follows: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !powered_down |=> pins.fast == $past(slew_fast))
    else $error("slew output does not follow configuration");

  // R7
  a_settle_length: assert property (@(posedge clk) disable iff (sys_rst)
    ce && state == pdrl_pkg::ST_SETTLE && settle_done && supply_sync
    |=> running && core_q == '0)
    else $error("initialisation did not end after settle");

  // R10
  a_verify_locked: assert property (@(posedge clk) disable iff (sys_rst)
    ce && rd && sel_verify && cfg.lock |=> rdata == '0)
    else $error("pattern readable under lock");

  // R11
  a_id_readable: assert property (@(posedge clk) disable iff (sys_rst)
    ce && rd && sel_id |=> rdata == ID_VALUE)
    else $error("identification not readable");

  // R13
  a_jtag_release: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg.jtag_en && !isp_locked |-> jtag_pin_oe == user_jtag_oe)
    else $error("disabled JTAG pins not released");

  // R14
  a_abort_float: assert property (@(posedge clk) disable iff (sys_rst)
    ce && prog_busy && prog_abort && !prog_done ##1 ce [*2]
    |-> pins.oe == '0)
    else $error("outputs driven after interrupted programming");

  // R15
  a_tap_reset_up: assert property (@(posedge clk) disable iff (sys_rst)
    state == pdrl_pkg::ST_SETTLE |-> tap_rst)
    else $error("test port not reset during power-up");

  // R16
  a_resume_no_init: assert property (@(posedge clk) disable iff (sys_rst)
    ce && powered_down && !pd_req && supply_sync |=> running && !tap_rst)
    else $error("resume went through initialisation");

endmodule : pdrl_ctrl

//--- pdrl_far.sv
/*
  Far-side system model: supply detect level and the logic pins.
  Assumes the bench requests levels; the model applies them on clk.
*/
`timescale 1ns/1ps
module pdrl_far (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ready,
  input wire logic supply_req,
  input wire logic pd_a_req,
  input wire logic pd_b_req,
  input wire logic [5:0] data_req,
  output logic supply_ok,
  output logic [7:0] pin_in
);
  logic seen_ready;

  always_ff @(posedge clk)
  begin
    supply_ok <= supply_req;
    seen_ready <= !sys_rst && (seen_ready || ready);
    // pins stay still until settle ends.
    if (!seen_ready)
      pin_in <= 8'h00;
    else
      pin_in <= {data_req, pd_b_req, pd_a_req};
  end
endmodule : pdrl_far

//--- pdrl_pkg.sv
/*
  Shared constants, register map and carrier types of the power-down,
  power-up reset and lock control block.
  Assumes a 250 MHz core clock and a plain register port with 8-bit
  byte addresses and 32-bit data.
*/
package pdrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NPIN = 8;
  localparam int NJTAG = 4;

  // Register byte offsets.
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] SLEW_OFS = 8'h04;
  localparam logic [7:0] POLAR_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] SIG_OFS = 8'h10;
  localparam logic [7:0] ID_OFS = 8'h14;
  localparam logic [7:0] VERIFY_OFS = 8'h18;

  // Configuration register field positions.
  localparam int PD_EN_BIT = 0;
  localparam int ROLE_A_BIT = 1;
  localparam int ROLE_B_BIT = 2;
  localparam int JTAG_EN_BIT = 3;
  localparam int LOCK_BIT = 4;
  localparam int CFG_W = 5;

  // Status register field positions.
  localparam int ST_READY_BIT = 0;
  localparam int ST_PDOWN_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_ABORT_BIT = 3;

  // Pins that may carry the power-down role.
  localparam int PD_A_PIN = 0;
  localparam int PD_B_PIN = 1;

  // Reset values.
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h08;
  localparam logic [NPIN-1:0] SLEW_RESET = 8'h00;
  localparam logic [NPIN-1:0] POLAR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SIG_RESET = 32'h0000_0000;

  // Power-up settle interval, in its own unit and in clock cycles.
  localparam int RESET_SETTLE_TIME_NS = 1000;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETTLE_CYC =
    (RESET_SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 9;

  typedef enum logic [1:0]
  {
    ST_OFF = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b11,
    ST_PDOWN = 2'b10
  } pdrl_state_t;

  typedef struct packed
  {
    logic lock;
    logic jtag_en;
    logic role_b;
    logic role_a;
    logic pd_en;
  } pdrl_cfg_t;

  typedef struct packed
  {
    logic [NPIN-1:0] level;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] fast;
  } pdrl_pins_t;

endpackage : pdrl_pkg

//--- pdrl_sync.sv
/*
  Two-flop synchroniser for a group of level signals.
  Assumes the inputs are asynchronous to clk; the first stage is read
  only by the second.
*/
`timescale 1ns/1ps
module pdrl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pdrl_sync

//--- testbench.sv
/*
  Self-checking bench for the power-down, reset and lock control block.
  Assumes the far-side model pdrl_far and the package constants.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, ce, sys_rst, supply_req, pd_a_req, pd_b_req, supply_ok;
  logic [5:0] data_req;
  logic [7:0] pin_in, core_d, out_oe_req, core_q, pin_data, pol, slw;
  logic [3:0] jtag_pin_in, jtag_pin_out, jtag_pin_oe, user_jtag_out;
  logic [3:0] user_jtag_oe, user_jtag_in, tap_pins;
  logic tap_tdo, tap_rst, prog_start, prog_done, prog_abort;
  logic powered_down, ready, wr, rd, rd_seen;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  pdrl_pkg::pdrl_pins_t pins;
  logic [31:0] exp_q[$];
  int fails, n_tests, cyc_cnt, t0;
  localparam logic [31:0] ID = 32'h0c3c_0002; // Arbitrary value.

  pdrl_far u_pdrl_far (.clk, .sys_rst, .ready, .supply_req, .pd_a_req,
    .pd_b_req, .data_req, .supply_ok, .pin_in);
  pdrl_ctrl #(.ID_VALUE(ID)) u_pdrl_ctrl (.clk, .ce, .sys_rst, .supply_ok,
    .pin_in, .core_d, .out_oe_req, .core_q, .pin_data, .pins, .jtag_pin_in,
    .jtag_pin_out, .jtag_pin_oe, .user_jtag_out, .user_jtag_oe,
    .user_jtag_in, .tap_pins, .tap_tdo, .tap_rst, .prog_start, .prog_done,
    .prog_abort, .powered_down, .ready, .addr, .wdata, .wr, .rd, .rdata);

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (rd_seen === 1'b1)
      chk("rdata", exp_q.pop_front(), rdata);
    rd_seen <= rd;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg

  task automatic pulse(input int k);
    case (k)
      0: prog_start <= 1'b1;
      1: prog_done <= 1'b1;
      default: prog_abort <= 1'b1;
    endcase
    @(posedge clk);
    {prog_start, prog_done, prog_abort} <= 3'b000;
    @(posedge clk);
  endtask : pulse

  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : look

  task automatic wait_on(input bit pd, input logic v, input int lim);
    int i;
    i = 0;
    @(negedge clk);
    while (i < lim && (pd ? powered_down : ready) !== v)
    begin
      @(negedge clk);
      i++;
    end
    chk(pd ? "powered_down" : "ready", v, pd ? powered_down : ready);
    @(posedge clk);
  endtask : wait_on

  task automatic load_cfg(input logic [31:0] c, s, p, g);
    pulse(0);
    wr_reg(pdrl_pkg::CFG_OFS, c);
    wr_reg(pdrl_pkg::SLEW_OFS, s);
    wr_reg(pdrl_pkg::POLAR_OFS, p);
    wr_reg(pdrl_pkg::SIG_OFS, g);
    pulse(1);
    slw = s[7:0];
    pol = p[7:0];
    rd_reg(pdrl_pkg::SLEW_OFS, s & 32'hff);
    rd_reg(pdrl_pkg::POLAR_OFS, p & 32'hff);
    rd_reg(pdrl_pkg::SIG_OFS, g);
    rd_reg(pdrl_pkg::VERIFY_OFS, c[4] ? 32'h0 : c);
  endtask : load_cfg

  task automatic pdown(input bit b);
    logic [7:0] q, l, pd;
    if (b)
      pd_b_req <= 1'b1;
    else
      pd_a_req <= 1'b1;
    wait_on(1, 1, 10);
    @(negedge clk);
    q = core_q;
    l = pins.level;
    pd = pin_data;
    @(posedge clk);
    core_d <= $urandom;
    data_req <= $urandom;
    look(10);
    chk("core_q held", q, core_q);
    chk("level held", l, pins.level);
    chk("pin_data held", pd, pin_data);
    @(posedge clk);
    pd_a_req <= 1'b0;
    pd_b_req <= 1'b0;
    wait_on(1, 0, 10);
    look(3);
    chk("ready", 1, ready);
    chk("core_q", core_d, core_q);
    chk("level", core_d ^ pol, pins.level);
    @(posedge clk);
  endtask : pdown

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("[ERR] watchdog expected end seen hang");
    results();
  end

  initial
  begin
    {ce, sys_rst} = 2'b11;
    {supply_req, pd_a_req, pd_b_req, wr, rd, rd_seen} = '0;
    {prog_start, prog_done, prog_abort, tap_tdo} = '0;
    {data_req, core_d, out_oe_req, addr, wdata} = '0;
    {jtag_pin_in, user_jtag_out, user_jtag_oe} = '0;
    {fails, n_tests, cyc_cnt} = '0;
    {pol, slw} = '0;
    void'($urandom(32'hdf66));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    supply_req <= 1'b1;
    t0 = cyc_cnt;
    rd_reg(pdrl_pkg::CFG_OFS, 32'(pdrl_pkg::CFG_RESET));
    rd_reg(pdrl_pkg::ID_OFS, ID);
    rd_reg(pdrl_pkg::SIG_OFS, pdrl_pkg::SIG_RESET);
    rd_reg(8'h1c, 32'h0);
    wr_reg(pdrl_pkg::CFG_OFS, 32'h1f);
    rd_reg(pdrl_pkg::CFG_OFS, 32'h08);
    look(0);
    chk("tap_rst", 1, tap_rst);
    chk("level", 0, pins.level);
    @(posedge clk);
    wait_on(0, 1, 300);
    chk("settle", 1, cyc_cnt - t0 >= pdrl_pkg::SETTLE_CYC);
    chk("tap_rst", 0, tap_rst);
    $display("test reset and settle done");
    jtag_pin_in <= $urandom;
    tap_tdo <= 1'b1;
    data_req <= $urandom;
    pd_b_req <= 1'b1;
    look(6);
    chk("tap_pins", jtag_pin_in, tap_pins);
    chk("jtag_pin_oe", 4'b1000, jtag_pin_oe);
    chk("jtag_pin_out", 1, jtag_pin_out[3]);
    chk("user_jtag_in", 0, user_jtag_in);
    chk("powered_down", 0, powered_down);
    chk("pin_data", {data_req, 2'b10}, pin_data);
    @(posedge clk);
    $display("test idle pins done");
    load_cfg(32'h0b, $urandom, $urandom, $urandom);
    core_d <= $urandom;
    out_oe_req <= 8'hff;
    look(4);
    chk("fast", slw, pins.fast);
    chk("oe", 8'hfe, pins.oe);
    chk("level", core_d ^ pol, pins.level);
    chk("powered_down", 0, powered_down);
    @(posedge clk);
    pd_b_req <= 1'b0;
    pdown(0);
    $display("test power-down a done");
    load_cfg(32'h15, $urandom, $urandom, $urandom);
    rd_reg(pdrl_pkg::STATUS_OFS, 32'h5);
    rd_reg(pdrl_pkg::ID_OFS, ID);
    user_jtag_out <= $urandom;
    user_jtag_oe <= $urandom;
    jtag_pin_in <= $urandom;
    pd_a_req <= 1'b1;
    look(6);
    chk("jtag_pin_out", user_jtag_out, jtag_pin_out);
    chk("jtag_pin_oe", user_jtag_oe, jtag_pin_oe);
    chk("user_jtag_in", jtag_pin_in, user_jtag_in);
    chk("tap_pins", 0, tap_pins);
    chk("powered_down", 0, powered_down);
    chk("pin_data0", 1, pin_data[0]);
    @(posedge clk);
    pd_a_req <= 1'b0;
    pdown(1);
    $display("test lock and power-down b done");
    user_jtag_oe <= 4'hf;
    pulse(0);
    pulse(2);
    look(2);
    chk("oe", 0, pins.oe);
    chk("jtag_pin_oe", 0, jtag_pin_oe);
    @(posedge clk);
    rd_reg(pdrl_pkg::STATUS_OFS, 32'hd);
    ce <= 1'b0;
    core_d <= core_d ^ 8'hff;
    look(3);
    chk("core_q frozen", core_d ^ 8'hff, core_q);
    @(posedge clk);
    ce <= 1'b1;
    look(3);
    chk("core_q", core_d, core_q);
    @(posedge clk);
    $display("test abort done");
    results();
  end
endmodule : testbench
